// >>> hw/rf_timer_pkg.sv
package rf_timer_pkg;

    // Register offsets on the device register port
    localparam logic [5:0] TIMER_MODE_OFFSET     = 6'h2a;
    localparam logic [5:0] PRESCALER_LOW_OFFSET  = 6'h2b;
    localparam logic [5:0] RELOAD_HIGH_OFFSET    = 6'h2c;
    localparam logic [5:0] RELOAD_LOW_OFFSET     = 6'h2d;
    localparam logic [5:0] COUNT_UPPER_OFFSET    = 6'h2e;
    localparam logic [5:0] COUNT_LOWER_OFFSET    = 6'h2f;

    // Index of each writable register inside the config array
    localparam int CFG_MODE      = 0;
    localparam int CFG_PRESC_LOW = 1;
    localparam int CFG_RELOAD_HI = 2;
    localparam int CFG_RELOAD_LO = 3;
    localparam int CFG_COUNT     = 4;
    // Offset low bits plus this give the array index
    localparam logic [1:0] CFG_INDEX_ADJUST = 2'h2;

    localparam logic [7:0] CFG_RESET_VALUE = 8'h00;

    // Timer mode register fields
    localparam int MODE_AUTO_BIT    = 7;
    localparam int MODE_GATE_MSB    = 6;
    localparam int MODE_GATE_LSB    = 5;
    localparam int MODE_RESTART_BIT = 4;
    localparam int MODE_NIBBLE_MSB  = 3;

    // Gate source encodings
    localparam logic [1:0] GATE_NONE      = 2'h0;
    localparam logic [1:0] GATE_SIGNAL_IN = 2'h1;
    localparam logic [1:0] GATE_AUX_ONE   = 2'h2;
    localparam logic [1:0] GATE_ADDR_3    = 2'h3;

    // Received bits after which protocol auto-start stops the timer
    localparam logic [2:0] RX_STOP_BITS_106AB  = 3'h5;
    localparam logic [2:0] RX_STOP_BITS_OTHER  = 3'h4;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } reg_access_t;

    typedef struct packed {
        logic signal_input_pin;
        logic auxiliary_pin_one;
        logic address_pin_three;
    } gate_pins_t;

    typedef enum {
        T_IDLE,
        T_COUNT
    } timer_state_t;

endpackage : rf_timer_pkg

// >>> hw/rf_timer_prescale_reload.sv
// Behaviour
// - gate_source_select 00 none, 01 signal input, 10 aux one, 11 address three.
// - In gated mode count_active_flag is one whenever the timer is enabled.
// - count_active_flag never feeds the gating signal; only the pin does.
// - reload_on_expiry one restarts countdown from reload_value at expiry.
// - reload_on_expiry zero counts to zero then sets expiry_request_flag.
// - divider_value is mode bits 3..0 above the 8-bit prescaler register.
// - Even select zero: tick equals reference over twice divider plus one.
// - Even select one: tick equals reference over twice divider plus two.
// - even_divide_select is taken straight from even_divide_select_i, with no register and no reset value.
// - Reload value is 16 bits held as two RW bytes, reset zero.
// - Every start event copies reload_value into the counter.
// - Reload writes do not disturb a running count until next start or auto-restart reload at expiry.
// - protocol_auto_start starts at transmit end or field on with option.
// - Auto-start without multiple receive stops after bit 5 or bit 4.
// - Counter is readable as upper byte then lower byte registers.
`timescale 1ns/1ns
`default_nettype none
module rf_timer_prescale_reload
    import rf_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Register port
    input  wire logic        wr_en_i,
    input  wire reg_access_t wr_i,
    input  wire logic        rd_en_i,
    input  wire logic [5:0]  rd_addr_i,
    output logic      [7:0]  rd_data_o,
    // Gate pins, asynchronous
    input  wire gate_pins_t  pins_i,
    // Reference and control, same clock
    input  wire logic        ref_tick_i,
    input  wire logic        even_divide_select_i,
    input  wire logic        start_now_i,
    input  wire logic        stop_now_i,
    input  wire logic        expiry_clear_i,
    // Protocol events, same clock
    input  wire logic        tx_end_i,
    input  wire logic        field_on_i,
    input  wire logic        initial_field_option_i,
    input  wire logic        multiple_receive_option_i,
    input  wire logic        rx_bit_i,
    input  wire logic        type_ab_106_i,
    // Status
    output logic             count_active_o,
    output logic             expiry_request_o
);

    logic         rst_meta_ff;
    logic         rst_n_ff;
    gate_pins_t   pins_meta_ff;
    gate_pins_t   pins_ff;
    logic [7:0]   cfg_ff [CFG_COUNT];
    logic [12:0]  presc_ff;
    logic [15:0]  count_ff;
    logic [2:0]   rx_cnt_ff;
    logic         expiry_ff;
    logic [7:0]   rd_data_ff;
    logic         active_ff;
    timer_state_t state_ff;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pins_meta_ff <= '0;
            pins_ff      <= '0;
        end else begin
            pins_meta_ff <= pins_i;
            pins_ff      <= pins_meta_ff;
        end
    end

    // Register decode
    wire        cfg_hit   = wr_i.addr >= TIMER_MODE_OFFSET
                         && wr_i.addr <= RELOAD_LOW_OFFSET;
    wire [1:0]  cfg_idx   = wr_i.addr[1:0] + CFG_INDEX_ADJUST;
    wire [7:0]  mode      = cfg_ff[CFG_MODE];
    wire        auto_on   = mode[MODE_AUTO_BIT];
    wire [1:0]  gate_sel  = mode[MODE_GATE_MSB:MODE_GATE_LSB];
    wire        restart   = mode[MODE_RESTART_BIT];
    wire [11:0] divider_value = {mode[MODE_NIBBLE_MSB:0],
                                 cfg_ff[CFG_PRESC_LOW]};
    wire [15:0] reload_value  = {cfg_ff[CFG_RELOAD_HI],
                                 cfg_ff[CFG_RELOAD_LO]};

    // writes only land in config, not the counter
    genvar gi;
    generate
        for (gi = 0; gi < CFG_COUNT; gi++) begin : g_cfg
            always_ff @(posedge clk_i or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    cfg_ff[gi] <= CFG_RESET_VALUE;
                end else if (wr_en_i && cfg_hit && cfg_idx == 2'(gi)) begin
                    cfg_ff[gi] <= wr_i.data;
                end
            end
        end
    endgenerate

    // gate is built from pins alone
    wire gate_open = (gate_sel == GATE_NONE)
                  || (gate_sel == GATE_SIGNAL_IN && pins_ff.signal_input_pin)
                  || (gate_sel == GATE_AUX_ONE && pins_ff.auxiliary_pin_one)
                  || (gate_sel == GATE_ADDR_3 && pins_ff.address_pin_three);

    wire running = (state_ff == T_COUNT);

    wire start = start_now_i
              || (auto_on && (tx_end_i
                              || (field_on_i && initial_field_option_i)));

    wire [2:0] rx_limit  = type_ab_106_i ? RX_STOP_BITS_106AB
                                         : RX_STOP_BITS_OTHER;
    wire       rx_watch  = running && auto_on && !multiple_receive_option_i;
    wire       rx_count  = rx_watch && rx_bit_i;
    wire       rx_stop   = rx_count && (rx_cnt_ff + 3'h1 == rx_limit);
    wire [2:0] nxt_rx_cnt = start ? 3'h0 : rx_count ? rx_cnt_ff + 3'h1
                                                    : rx_cnt_ff;

    // odd factor 2P+1; even factor 2P+2 (load plus one ticks)
    // even select is taken straight from even_divide_select_i, with no register
    wire [12:0] presc_load = {divider_value, 1'b0}
                           + {12'h000, even_divide_select_i};
    wire        timer_tick = running && ref_tick_i && presc_ff == '0;
    wire [12:0] nxt_presc  = start ? presc_load
                           : !(running && ref_tick_i) ? presc_ff
                           : timer_tick ? presc_load : presc_ff - 13'h1;

    // counter steps only while gate open
    wire        count_step = timer_tick && gate_open;
    wire        expire     = count_step && count_ff == '0;
    wire [15:0] nxt_count  = start ? reload_value
                           : !count_step ? count_ff
                           : count_ff != '0 ? count_ff - 16'h1
                           : restart ? reload_value : count_ff;

    // expiry sets flag; set wins over clear
    wire nxt_expiry = expire || (expiry_ff && !expiry_clear_i);

    timer_state_t nxt_state;
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            T_IDLE: begin
                if (start) nxt_state = T_COUNT;
            end
            T_COUNT: begin
                if (start) nxt_state = T_COUNT;
                else if (stop_now_i || rx_stop) nxt_state = T_IDLE;
                else if (expire && !restart) nxt_state = T_IDLE;
            end
            default: nxt_state = T_IDLE;
        endcase
    end

    // Registered copy so the status pin comes from a flop
    wire nxt_active = (nxt_state == T_COUNT);

    wire [7:0] rd_mux =
        (rd_addr_i == TIMER_MODE_OFFSET)    ? cfg_ff[CFG_MODE]      :
        (rd_addr_i == PRESCALER_LOW_OFFSET) ? cfg_ff[CFG_PRESC_LOW] :
        (rd_addr_i == RELOAD_HIGH_OFFSET)   ? cfg_ff[CFG_RELOAD_HI] :
        (rd_addr_i == RELOAD_LOW_OFFSET)    ? cfg_ff[CFG_RELOAD_LO] :
        (rd_addr_i == COUNT_UPPER_OFFSET)   ? count_ff[15:8]        :
        (rd_addr_i == COUNT_LOWER_OFFSET)   ? count_ff[7:0]         :
                                              8'h00;
    wire [7:0] nxt_rd_data = rd_en_i ? rd_mux : rd_data_ff;

    always_ff @(posedge clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff   <= T_IDLE;
            presc_ff   <= '0;
            count_ff   <= '0;
            rx_cnt_ff  <= '0;
            expiry_ff  <= 1'b0;
            rd_data_ff <= 8'h00;
            active_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            presc_ff   <= nxt_presc;
            count_ff   <= nxt_count;
            rx_cnt_ff  <= nxt_rx_cnt;
            expiry_ff  <= nxt_expiry;
            rd_data_ff <= nxt_rd_data;
            active_ff  <= nxt_active;
        end
    end

    // active flag is the enable state, not the gate level
    assign count_active_o   = active_ff;
    assign expiry_request_o = expiry_ff;
    assign rd_data_o        = rd_data_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_ff);

    a_start_loads_reload: assert property (
        start |=> count_ff == $past(reload_value) && count_active_o)
        else $error("start did not load reload value");

    a_reload_write_quiet: assert property (
        wr_en_i && (wr_i.addr == RELOAD_HIGH_OFFSET
                    || wr_i.addr == RELOAD_LOW_OFFSET)
        && !start && !count_step |=> $stable(count_ff))
        else $error("reload write disturbed counter");

    a_odd_prescale: assert property (
        timer_tick && !start && !even_divide_select_i
        |=> presc_ff == {$past(divider_value), 1'b0})
        else $error("odd divide load wrong");

    a_even_prescale: assert property (
        timer_tick && !start && even_divide_select_i
        |=> presc_ff == {$past(divider_value), 1'b0} + 13'h1)
        else $error("even divide load wrong");

    a_gate_holds_count: assert property (
        running && !gate_open && !start |=> $stable(count_ff))
        else $error("counter moved with gate closed");

    a_expiry_stops: assert property (
        expire && !restart && !start
        |=> expiry_request_o && !count_active_o)
        else $error("expiry did not flag and stop");

    a_restart_reloads: assert property (
        expire && restart && !start && !stop_now_i && !rx_stop
        |=> count_ff == $past(reload_value) && count_active_o)
        else $error("auto restart failed");

    a_active_gated: assert property (
        gate_sel != GATE_NONE && running && !gate_open
        && !stop_now_i && !rx_stop |=> count_active_o)
        else $error("active flag follows gate");

    a_gate_signal_in: assert property (
        gate_sel == GATE_SIGNAL_IN |-> gate_open == pins_ff.signal_input_pin)
        else $error("signal input gate wrong");

    a_rx_stop_bits: assert property (
        rx_stop && !start |=> !count_active_o ##1 !count_active_o || start)
        else $error("receive bit stop failed");

    c_expire_stop: cover property (expire && !restart);
    c_expire_restart: cover property (expire && restart);
    c_gated_hold: cover property (running && !gate_open ##1 count_step);
    c_rx_stop: cover property (rx_stop);

endmodule : rf_timer_prescale_reload
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import rf_timer_pkg::*;
    logic        clk_i     = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        wr_en_i   = 1'b0;
    logic        rd_en_i   = 1'b0;
    reg_access_t wr_i      = '0;
    logic [5:0]  rd_addr_i = 6'h00;
    logic [7:0]  rd_data_o;
    gate_pins_t  pins_i    = '0;
    logic        ref_tick_i = 1'b0;
    logic        even_i    = 1'b0;
    logic        opt_i     = 1'b0;
    logic        mult_i    = 1'b0;
    logic        ab_i      = 1'b1;
    logic [5:0]  ctl       = 6'h00;
    logic        count_active_o;
    logic        expiry_request_o;
    logic        rd_d      = 1'b0;
    logic [7:0]  exp_q[$];
    logic [31:0] seed      = 32'hdd65;
    logic [31:0] r;
    int          failures  = 0;
    int          total_checks = 0;
    int          a, b, c, d, e;

    rf_timer_prescale_reload rf_timer_prescale_reload_inst (
        .clk_i, .arst_n_i, .wr_en_i, .wr_i, .rd_en_i, .rd_addr_i,
        .rd_data_o, .pins_i, .ref_tick_i,
        .even_divide_select_i(even_i), .start_now_i(ctl[0]),
        .stop_now_i(ctl[1]), .expiry_clear_i(ctl[2]), .tx_end_i(ctl[3]),
        .field_on_i(ctl[4]), .initial_field_option_i(opt_i),
        .multiple_receive_option_i(mult_i), .rx_bit_i(ctl[5]),
        .type_ab_106_i(ab_i), .count_active_o, .expiry_request_o
    );

    initial forever #4 clk_i = ~clk_i;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk_byte(string n, logic [7:0] x, logic [7:0] g);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk_byte

    task automatic chk_flag(string n, logic x, logic g);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", n, x, g);
        end
    endtask : chk_flag

    task automatic chk_cyc(string n, int x, int g);
        total_checks++;
        if (g != x) begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", n, x, g);
        end
    endtask : chk_cyc

    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [5:0] ad, input logic [7:0] dt);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        wr_i    <= '{addr: ad, data: dt};
        @(posedge clk_i);
        wr_en_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] ad, input logic [7:0] x);
        @(posedge clk_i);
        rd_en_i   <= 1'b1;
        rd_addr_i <= ad;
        exp_q.push_back(x);
        @(posedge clk_i);
        rd_en_i   <= 1'b0;
    endtask : rd

    task automatic pulse(input int k);
        @(posedge clk_i);
        ctl[k] <= 1'b1;
        @(posedge clk_i);
        ctl[k] <= 1'b0;
    endtask : pulse

    task automatic setp(input logic [7:0] m, input logic [7:0] lo);
        wr(TIMER_MODE_OFFSET, m);
        wr(PRESCALER_LOW_OFFSET, lo);
    endtask : setp

    // Cycles from start to expiry; fixed offsets cancel in differences
    task automatic meas(output int n);
        pulse(0);
        n = 0;
        while (expiry_request_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        chk_flag("active after expiry", 1'b0, count_active_o);
        pulse(2);
    endtask : meas

    always @(posedge clk_i) rd_d <= rd_en_i;
    always @(negedge clk_i)
        if (rd_d) chk_byte("read data", exp_q.pop_front(), rd_data_o);

    initial begin
        #400000;
        failures++;
        end_of_test();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 5; i++)
            rd(i < 4 ? 6'(6'h2a + i) : 6'h3f, 8'h00);
        r = xs();
        wr(RELOAD_HIGH_OFFSET, r[7:0]);
        wr(RELOAD_LOW_OFFSET, r[15:8]);
        wr(COUNT_UPPER_OFFSET, 8'hff);
        rd(RELOAD_HIGH_OFFSET, r[7:0]);
        rd(RELOAD_LOW_OFFSET, r[15:8]);
        rd(COUNT_UPPER_OFFSET, 8'h00);
        $display("end of test: registers");
        wr(RELOAD_HIGH_OFFSET, 8'h03);
        wr(RELOAD_LOW_OFFSET, 8'h05);
        pulse(0);
        rd(COUNT_UPPER_OFFSET, 8'h03);
        rd(COUNT_LOWER_OFFSET, 8'h05);
        wr(RELOAD_HIGH_OFFSET, 8'h01);
        wr(RELOAD_LOW_OFFSET, 8'h00);
        rd(COUNT_LOWER_OFFSET, 8'h05);
        pulse(0);
        rd(COUNT_UPPER_OFFSET, 8'h01);
        rd(COUNT_LOWER_OFFSET, 8'h00);
        pulse(1);
        $display("end of test: reload");
        wr(RELOAD_HIGH_OFFSET, 8'h00);
        wr(RELOAD_LOW_OFFSET, 8'h01);
        ref_tick_i <= 1'b1;
        setp(8'h00, 8'h00);
        meas(e);
        setp(8'h00, 8'h01);
        meas(a);
        chk_cyc("odd factor P1", 4, a - e);
        even_i <= 1'b1;
        meas(b);
        chk_cyc("even factor", 2, b - a);
        even_i <= 1'b0;
        setp(8'h00, 8'h02);
        meas(c);
        chk_cyc("odd factor P2", 4, c - a);
        setp(8'h01, 8'h00);
        meas(d);
        chk_cyc("upper nibble", 1024, d - e);
        $display("end of test: prescaler");
        setp(8'h10, 8'h00);
        pulse(0);
        repeat (20) @(negedge clk_i);
        chk_flag("restart flag", 1'b1, expiry_request_o);
        chk_flag("restart active", 1'b1, count_active_o);
        pulse(1);
        pulse(2);
        $display("end of test: restart");
        // each gate source, other pins high
        for (int g = 1; g < 4; g++) begin
            pins_i <= gate_pins_t'(~(3'b100 >> (g - 1)));
            wr(TIMER_MODE_OFFSET, 8'(g << 5));
            pulse(0);
            repeat (20) @(negedge clk_i);
            chk_flag("gated hold", 1'b0, expiry_request_o);
            chk_flag("gated active", 1'b1, count_active_o);
            rd(COUNT_LOWER_OFFSET, 8'h01);
            pins_i <= gate_pins_t'(3'b111);
            repeat (12) @(negedge clk_i);
            chk_flag("gated expiry", 1'b1, expiry_request_o);
            pulse(2);
        end
        $display("end of test: gating");
        ref_tick_i <= 1'b0;
        wr(TIMER_MODE_OFFSET, 8'h80);
        pulse(3);
        @(negedge clk_i);
        chk_flag("tx end start", 1'b1, count_active_o);
        repeat (4) pulse(5);
        @(negedge clk_i);
        chk_flag("after four bits", 1'b1, count_active_o);
        pulse(5);
        @(negedge clk_i);
        chk_flag("after five bits", 1'b0, count_active_o);
        pulse(4);
        @(negedge clk_i);
        chk_flag("field no option", 1'b0, count_active_o);
        @(posedge clk_i);
        opt_i <= 1'b1;
        pulse(4);
        @(negedge clk_i);
        chk_flag("field option", 1'b1, count_active_o);
        pulse(1);
        ab_i   <= 1'b0;
        mult_i <= 1'b1;
        pulse(3);
        repeat (5) pulse(5);
        @(negedge clk_i);
        chk_flag("multiple receive", 1'b1, count_active_o);
        pulse(1);
        mult_i <= 1'b0;
        pulse(3);
        repeat (3) pulse(5);
        @(negedge clk_i);
        chk_flag("after three bits", 1'b1, count_active_o);
        pulse(5);
        @(negedge clk_i);
        chk_flag("after four bits other", 1'b0, count_active_o);
        $display("end of test: protocol");
        repeat (3) @(posedge clk_i);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
